// file: nested_irq_and_standby_ctrl.sv
`timescale 1ns/1ps

// Behaviour
// - High-priority service: nest only priority-0 with enable
// - Low or idle service: nest either priority with enable
// - Enable flag clear refuses every maskable nesting
// - One priority flag per source, 0 is high
// - Non-maskable service refuses all nested interrupts
// - Refused request pends until one instruction after return
// - Status-word, enable, disable, return instructions defer maskable acceptance
// - Flag and mode register writes defer maskable acceptance too
// - Break clears enable; non-maskable still accepted
// - Halt gates CPU clock, oscillator keeps running
// - Stop halts oscillator, or enters halt if a request is pending; interrupt clears after settling
// - Standby keeps all registers and port state
// - Unmasked request clears halt; vector only if enabled
// - Reset loads settle select register with 04H
// - Reset-cleared stop waits 2^17 oscillator periods
// - Settle code selects 2^12..2^17 system periods
// - Settle count starts only after oscillation starts
// - Clock select bit picks oscillator or half rate
module nested_irq_and_standby_ctrl
  import irq_standby_pkg::*;
#(
  parameter int NUM_SRC = 24
)(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // Register access from the CPU data bus
  input  wire logic [15:0]        reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  output logic      [7:0]         reg_rdata,
  // Interrupt sources, flags held in the request, mask and priority registers
  input  wire logic [NUM_SRC-1:0] request_flag,
  input  wire logic [NUM_SRC-1:0] mask_flag,
  input  wire logic [NUM_SRC-1:0] source_priority_flag,
  input  wire logic               nmi_request,
  // Instruction sequencer
  input  wire logic               instr_done,
  input  wire logic               instr_defers,
  input  wire logic               break_instruction,
  input  wire logic               return_from_interrupt,
  input  wire logic               return_from_break,
  input  wire logic               enable_interrupts_instr,
  input  wire logic               disable_interrupts_instr,
  input  wire logic               halt_instr,
  input  wire logic               stop_instr,
  input  wire logic               clock_divide_select,
  // Oscillator
  input  wire logic               osc_running_pin,
  input  wire logic               reset_cleared_stop,
  // Acceptance outputs
  output logic                    accept_maskable,
  output logic                    accept_nmi,
  output logic [NUM_SRC-1:0]      accept_sel,
  output logic                    irq_accept_enable,
  output logic                    in_service_priority,
  // Standby outputs
  output logic                    cpu_clk_gate,
  output logic                    osc_stop,
  output logic                    standby_resume
);

  localparam int CNT_W = 19;

  // Settle count in cycles of the divided or undivided system clock
  function automatic logic [CNT_W-1:0] settle_cycles(input logic [2:0] code,
                                                     input logic       undivided);
    logic [CNT_W-1:0] base;
    base = '0;
    case (code)
      SETTLE_2E12: base = CNT_W'(1) << 12;
      SETTLE_2E14: base = CNT_W'(1) << 14;
      SETTLE_2E15: base = CNT_W'(1) << 15;
      SETTLE_2E16: base = CNT_W'(1) << 16;
      SETTLE_2E17: base = CNT_W'(1) << 17;
      default:     base = CNT_W'(1) << 17;
    endcase
    settle_cycles = undivided ? base : (base << 1);
  endfunction : settle_cycles

  logic [SETTLE_SEL_W-1:0] settle_sel_reg;
  svc_kind_t               svc_reg;
  svc_kind_t               svc_next;
  pwr_state_t              pwr_reg;
  pwr_state_t              pwr_next;
  logic                    ie_reg;
  logic                    isp_reg;
  logic [CNT_W-1:0]        cnt_reg;
  logic                    osc_meta;
  logic                    osc_sync;
  logic [NUM_SRC-1:0]      req_sync_a;
  logic [NUM_SRC-1:0]      req_sync;
  logic                    nmi_meta;
  logic                    nmi_sync;

  // Request flags come from peripheral logic on other edges; synchronise
  // Only the second stage is read by any logic
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      req_sync_a <= '0;
      req_sync   <= '0;
    end
    else
    begin
      req_sync_a <= request_flag;
      req_sync   <= req_sync_a;
    end
  end

  // Non-maskable request synchroniser
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      nmi_meta <= 1'b0;
      nmi_sync <= 1'b0;
    end
    else
    begin
      nmi_meta <= nmi_request;
      nmi_sync <= nmi_meta;
    end
  end

  // Oscillator-started synchroniser
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
    end
    else
    begin
      osc_meta <= osc_running_pin;
      osc_sync <= osc_meta;
    end
  end

  // Pending: flag set and unmasked; priority plays no part in setting
  wire [NUM_SRC-1:0] pending   = req_sync & ~mask_flag;
  wire [NUM_SRC-1:0] pend_high = pending & ~source_priority_flag;
  wire               any_high  = |pend_high;
  wire               any_pend  = |pending;
  wire [NUM_SRC-1:0] pick_vec  = any_high ? pend_high : pending;
  wire [NUM_SRC-1:0] pick_one  = pick_vec & (~pick_vec + NUM_SRC'(1));

  // Nesting permission by service kind
  wire allow_by_kind =
    (svc_reg == SVC_NMI)      ? 1'b0 :
    (svc_reg == SVC_MASKABLE && !isp_reg) ? any_high :
    any_pend;

  wire running   = (pwr_reg == PWR_RUN) || (pwr_reg == PWR_HALT);
  // A reserve-class instruction blocks maskable acceptance at its own completion only;
  // the request is then taken when the following instruction completes
  wire reserve_instr = instr_defers || enable_interrupts_instr || disable_interrupts_instr
                       || return_from_interrupt || return_from_break;
  wire window_ok = instr_done && !reserve_instr;
  wire take_nmi  = nmi_sync && (svc_reg != SVC_NMI) && running && instr_done;
  wire take_mask = !take_nmi && ie_reg && allow_by_kind && window_ok
                   && (pwr_reg == PWR_RUN) && !break_instruction;
  wire wake      = any_pend || nmi_sync;

  wire settle_hit = (cnt_reg == CNT_W'(1));
  wire [CNT_W-1:0] settle_load = reset_cleared_stop
    ? (CNT_W'(1) << RESET_SETTLE_EXP)
    : settle_cycles(settle_sel_reg, clock_divide_select);

  always_comb
  begin
    svc_next = svc_reg;
    if (take_nmi)
      svc_next = SVC_NMI;
    else if (take_mask)
      svc_next = SVC_MASKABLE;
    else if (break_instruction && instr_done)
      svc_next = SVC_BREAK;
    else if ((return_from_interrupt || return_from_break) && instr_done)
      svc_next = SVC_NONE;
  end

  always_comb
  begin
    pwr_next = pwr_reg;
    case (pwr_reg)
      PWR_RUN:
      begin
        if (stop_instr && instr_done)
          pwr_next = wake ? PWR_HALT : PWR_STOP;
        else if (halt_instr && instr_done)
          pwr_next = PWR_HALT;
      end
      PWR_HALT:
      begin
        // Any unmasked request wakes, whether or not it is then accepted
        if (wake)
          pwr_next = PWR_RUN;
        else
          pwr_next = PWR_HALT;
      end
      PWR_STOP:
      begin
        // A wake source or a reset-cleared stop starts the settle wait
        if (wake || reset_cleared_stop)
          pwr_next = PWR_SETTLE;
        else
          pwr_next = PWR_STOP;
      end
      PWR_SETTLE:
      begin
        // Leave only once the running oscillator has finished the count
        if (osc_sync && settle_hit)
          pwr_next = PWR_RUN;
        else
          pwr_next = PWR_SETTLE;
      end
      default:    pwr_next = PWR_RUN;
    endcase
  end

  // Settle select register; only the low field is stored
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      settle_sel_reg <= SETTLE_SEL_RESET[SETTLE_SEL_W-1:0];
    else if (reg_wr && reg_addr == SETTLE_SEL_ADDR)
      settle_sel_reg <= reg_wdata[SETTLE_SEL_W-1:0];
  end

  // Enable and in-service flags; acceptance clears enable
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ie_reg  <= 1'b0;
      isp_reg <= 1'b1;
    end
    else if (take_nmi)
    begin
      ie_reg  <= 1'b0;
      isp_reg <= 1'b0;
    end
    else if (take_mask)
    begin
      ie_reg  <= 1'b0;
      isp_reg <= |(pick_one & source_priority_flag);
    end
    else if (break_instruction && instr_done)
      ie_reg  <= 1'b0;
    else if (enable_interrupts_instr && instr_done)
      ie_reg  <= 1'b1;
    else if (disable_interrupts_instr && instr_done)
      ie_reg  <= 1'b0;
    else if (return_from_interrupt && instr_done)
      isp_reg <= 1'b1;
  end

  // Service tracking; register state otherwise untouched in standby
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      svc_reg <= SVC_NONE;
    else
      svc_reg <= svc_next;
  end

  // Power state and settle counter; counting waits for oscillator start
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pwr_reg <= PWR_RUN;
      cnt_reg <= '0;
    end
    else
    begin
      pwr_reg <= pwr_next;
      if (pwr_reg == PWR_STOP)
        cnt_reg <= settle_load;
      else if (pwr_reg == PWR_SETTLE && osc_sync && !settle_hit)
        cnt_reg <= cnt_reg - CNT_W'(1);
    end
  end

  // Register read data
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= (reg_addr == SETTLE_SEL_ADDR)
                   ? {5'h00, settle_sel_reg} : 8'h00;
  end

  // Acceptance pulses and flag copies; the copies show the flags that
  // decided the acceptance reported in the same cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      accept_maskable     <= 1'b0;
      accept_nmi          <= 1'b0;
      accept_sel          <= '0;
      irq_accept_enable   <= 1'b0;
      in_service_priority <= 1'b1;
    end
    else
    begin
      accept_maskable     <= take_mask;
      accept_nmi          <= take_nmi;
      accept_sel          <= take_mask ? pick_one : '0;
      irq_accept_enable   <= ie_reg;
      in_service_priority <= isp_reg;
    end
  end

  // Standby outputs follow the next power state, so they change on
  // the edge that enters or leaves standby
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cpu_clk_gate   <= 1'b0;
      osc_stop       <= 1'b0;
      standby_resume <= 1'b0;
    end
    else
    begin
      cpu_clk_gate   <= (pwr_next != PWR_RUN);
      osc_stop       <= (pwr_next == PWR_STOP);
      standby_resume <= (pwr_reg != PWR_RUN) && (pwr_next == PWR_RUN);
    end
  end

endmodule : nested_irq_and_standby_ctrl

// file: irq_standby_pkg.sv
package irq_standby_pkg;

  // Register map
  localparam logic [15:0] SETTLE_SEL_ADDR  = 16'hFFFA;
  localparam logic [7:0]  SETTLE_SEL_RESET = 8'h04;
  localparam int          SETTLE_SEL_W     = 3;

  // Settle select codes
  localparam logic [2:0] SETTLE_2E12 = 3'h0;
  localparam logic [2:0] SETTLE_2E14 = 3'h1;
  localparam logic [2:0] SETTLE_2E15 = 3'h2;
  localparam logic [2:0] SETTLE_2E16 = 3'h3;
  localparam logic [2:0] SETTLE_2E17 = 3'h4;

  // Exponent of the settle wait after a reset-cleared stop, in oscillator periods
  localparam int RESET_SETTLE_EXP = 17;

  // Kind of service in progress
  typedef enum logic [1:0] {
    SVC_NONE     = 2'b00,
    SVC_MASKABLE = 2'b01,
    SVC_NMI      = 2'b10,
    SVC_BREAK    = 2'b11
  } svc_kind_t;

  // Power state
  typedef enum logic [1:0] {
    PWR_RUN    = 2'b00,
    PWR_HALT   = 2'b01,
    PWR_STOP   = 2'b10,
    PWR_SETTLE = 2'b11
  } pwr_state_t;

endpackage : irq_standby_pkg

// file: nested_irq_checker_assertions.sv
`timescale 1ns/1ps
module nested_irq_checker
  import irq_standby_pkg::*;
#(
  parameter int NUM_SRC = 24
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Sources and sequencer
  input wire logic [NUM_SRC-1:0] mask_flag,
  input wire logic [NUM_SRC-1:0] source_priority_flag,
  input wire logic instr_done,
  input wire logic instr_defers,
  input wire logic halt_instr,
  input wire logic stop_instr,
  // Outputs
  input wire logic [7:0] reg_rdata,
  input wire logic accept_maskable,
  input wire logic [NUM_SRC-1:0] accept_sel,
  input wire logic irq_accept_enable,
  input wire logic in_service_priority,
  input wire logic cpu_clk_gate,
  input wire logic osc_stop,
  input wire logic standby_resume
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_enable_gate: assert property (accept_maskable |-> irq_accept_enable)
    else $error("accepted while disabled");
  chk_high_only: assert property (
    accept_maskable && !in_service_priority
    |-> ($past(source_priority_flag) & accept_sel) == '0) else $error("low nested in high");
  chk_sel_unmasked: assert property (
    accept_maskable |-> $onehot(accept_sel) && ($past(mask_flag) & accept_sel) == '0)
    else $error("bad select");
  chk_defer_hold: assert property (instr_done && instr_defers |=> !accept_maskable)
    else $error("accepted on deferring");
  chk_accept_clears: assert property (
    accept_maskable |=> !irq_accept_enable && !accept_maskable) else $error("enable kept");
  chk_gate_cause: assert property (
    $rose(cpu_clk_gate) |-> $past(instr_done && (halt_instr || stop_instr)))
    else $error("gate without standby");
  chk_resume_form: assert property (
    standby_resume |-> !cpu_clk_gate && !osc_stop ##1 !standby_resume) else $error("bad resume");
  chk_rdata_zero: assert property (reg_rdata[7:3] == 5'h00) else $error("high bits set");

  cov_accept: cover property (accept_maskable);
  cov_halt: cover property ($rose(cpu_clk_gate) && !osc_stop);
  cov_resume: cover property (standby_resume);
endmodule : nested_irq_checker

bind nested_irq_and_standby_ctrl nested_irq_checker #(.NUM_SRC(NUM_SRC)) u_chk (
  .clk, .rst, .mask_flag, .source_priority_flag, .instr_done, .instr_defers, .halt_instr,
  .stop_instr, .reg_rdata, .accept_maskable, .accept_sel, .irq_accept_enable,
  .in_service_priority, .cpu_clk_gate, .osc_stop, .standby_resume);

// file: osc_model.sv
`timescale 1ns/1ps
module osc_model #(
  parameter int START_DLY = 20
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Oscillator control and status
  input wire logic osc_stop,
  output logic     osc_running_pin
);
  int start_cnt;
  // Dead while stopped, then a start-up delay before it runs
  always @(posedge clk or posedge rst)
    if (rst || osc_stop)
    begin
      start_cnt <= 0;
      osc_running_pin <= rst;
    end
    else if (start_cnt < START_DLY)
      start_cnt <= start_cnt + 1;
    else
      osc_running_pin <= 1'b1;
endmodule : osc_model

// file: tb_nested_irq_and_standby_ctrl.sv
`timescale 1ns/1ps
module tb_nested_irq_and_standby_ctrl
  import irq_standby_pkg::*;
;
  localparam int NS = 24;
  logic clk, rst, reg_wr, nmi_request, instr_done, instr_defers, break_instruction;
  logic enable_interrupts_instr, halt_instr, stop_instr, clock_divide_select;
  logic return_from_interrupt, disable_interrupts_instr;
  logic osc_running_pin, accept_maskable, accept_nmi, irq_accept_enable;
  logic in_service_priority, cpu_clk_gate, osc_stop, standby_resume;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [NS-1:0] request_flag, mask_flag, source_priority_flag, accept_sel;
  int fail_count, tests_run, cycles, n;

  nested_irq_and_standby_ctrl #(.NUM_SRC(NS)) u_dut (
    .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata, .request_flag, .mask_flag,
    .source_priority_flag, .nmi_request, .instr_done, .instr_defers, .break_instruction,
    .return_from_interrupt, .return_from_break(1'b0), .enable_interrupts_instr,
    .disable_interrupts_instr, .halt_instr, .stop_instr, .clock_divide_select,
    .osc_running_pin, .reset_cleared_stop(1'b0), .accept_maskable, .accept_nmi, .accept_sel,
    .irq_accept_enable, .in_service_priority, .cpu_clk_gate, .osc_stop, .standby_resume);
  osc_model u_osc (.clk, .rst, .osc_stop, .osc_running_pin);

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
    if (++cycles == 40000)
      stop_test(1);

  task automatic stop_test(input int hung);
    fail_count += hung;
    if (fail_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  task automatic chk(input string s, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
      $display("unexpected %s: expected %0h, seen %0h", s, exp, got);
    fail_count += (got !== exp);
  endtask : chk

  task automatic init();
    rst = 1'b1;
    {reg_wr, nmi_request, instr_done, instr_defers, break_instruction} = '0;
    {enable_interrupts_instr, halt_instr, stop_instr, reg_addr, reg_wdata} = '0;
    {return_from_interrupt, disable_interrupts_instr} = '0;
    {request_flag, mask_flag, source_priority_flag} = {{NS{1'b0}}, {2*NS{1'b1}}};
    clock_divide_select = 1'b1;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
  endtask : init

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(posedge clk) #1;
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    reg_addr = a;
    @(posedge clk) #1;
    chk("reg_rdata", exp, reg_rdata);
  endtask : rd

  // Unmasked request, given time to pass the synchroniser
  task automatic src(input int i, input logic pr);
    {request_flag[i], mask_flag[i], source_priority_flag[i]} = {2'b10, pr};
    repeat (3) @(posedge clk);
  endtask : src

  // Kinds: 0 plain, 1 enable, 2 flag write, 3 break, 4 halt, 5 stop, 6 return, 7 disable
  task automatic step(input int k, input logic acc, input logic [31:0] sel);
    @(posedge clk) #1;
    {instr_done, enable_interrupts_instr, instr_defers} = {1'b1, k == 1, k inside {1, 2, 6, 7}};
    {break_instruction, halt_instr, stop_instr} = {k == 3, k == 4, k == 5};
    {return_from_interrupt, disable_interrupts_instr} = {k == 6, k == 7};
    @(posedge clk) #1;
    {instr_done, enable_interrupts_instr, instr_defers} = '0;
    {break_instruction, halt_instr, stop_instr} = '0;
    {return_from_interrupt, disable_interrupts_instr} = '0;
    chk("accept_maskable", acc, accept_maskable);
    if (acc)
      chk("accept_sel", sel, accept_sel);
  endtask : step

  // Counts running oscillator cycles until the wake-up pulse
  task automatic wait_res();
    n = 0;
    for (int i = 0; i < 20000 && standby_resume !== 1'b1; i++)
    begin
      @(posedge clk) #1;
      n += (osc_running_pin === 1'b1);
    end
  endtask : wait_res

  initial
  begin
    init();
    rd(SETTLE_SEL_ADDR, SETTLE_SEL_RESET);
    chk("isp", 1, in_service_priority);
    wr(SETTLE_SEL_ADDR, 8'hFF);
    rd(SETTLE_SEL_ADDR, 8'h07);
    rd(16'hFFFB, 8'h00);
    src(3, 1'b0);
    step(0, 0, 0);
    step(1, 0, 0);
    step(7, 0, 0);
    step(0, 0, 0);
    step(1, 0, 0);
    step(2, 0, 0);
    step(0, 1, 32'h8);
    request_flag[3] = 1'b0;
    src(5, 1'b1);
    chk("isp", 0, in_service_priority);
    step(1, 0, 0);
    step(0, 0, 0);
    src(6, 1'b0);
    step(0, 1, 32'h40);
    init();
    src(5, 1'b1);
    step(1, 0, 0);
    step(0, 1, 32'h20);
    request_flag[5] = 1'b0;
    src(2, 1'b1);
    step(1, 0, 0);
    step(0, 1, 32'h4);
    init();
    nmi_request = 1'b1;
    src(1, 1'b0);
    step(0, 0, 0);
    chk("accept_nmi", 1, accept_nmi);
    nmi_request = 1'b0;
    step(1, 0, 0);
    step(0, 0, 0);
    step(6, 0, 0);
    step(0, 1, 32'h2);
    init();
    step(1, 0, 0);
    src(4, 1'b1);
    step(3, 0, 0);
    @(posedge clk) #1;
    chk("ie", 0, irq_accept_enable);
    step(1, 0, 0);
    step(0, 1, 32'h10);
    init();
    step(4, 0, 0);
    chk("cpu_clk_gate", 1, cpu_clk_gate);
    chk("osc_stop", 0, osc_stop);
    {request_flag[7], mask_flag[7]} = 2'b10;
    wait_res();
    chk("standby_resume", 1, standby_resume);
    for (int d = 1; d >= 0; d--)
    begin
      init();
      clock_divide_select = d[0];
      wr(SETTLE_SEL_ADDR, {5'h00, SETTLE_2E12});
      step(5, 0, 0);
      chk("osc_stop", 1, osc_stop);
      {request_flag[7], mask_flag[7]} = 2'b10;
      wait_res();
      chk("settle", 1, n >= 4096 * (2 - d) && n <= 4104 * (2 - d));
      rd(SETTLE_SEL_ADDR, 8'h00);
    end
    stop_test(0);
  end
endmodule : tb_nested_irq_and_standby_ctrl
